// ### hw/pwr_seq_regs.svh
// Constants for the rail sequencer: timing, register offsets, field positions.
// Assumes a single 40 MHz clock; included by the design files by bare name.
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CLK_MHZ 40
`define CLK_KHZ 40000
`define DSW_PG_DELAY_MS 10
`define DSW_PG_DELAY_CYC (`DSW_PG_DELAY_MS * `CLK_KHZ)
`define STEP_TIME_US 32
`define STEP_CYC (`STEP_TIME_US * `CLK_MHZ)
`define STEP_CFG_RST 16'(`STEP_CYC - 1)
`define AON_STEPS_DEF 3
`define SYS_STEPS_DEF 4
`define HUB_SW_STEP 4'h1
`define OFS_MON_EN 8'h00
`define OFS_STEP_CFG 8'h04
`define OFS_STATUS 8'h08
`define OFS_OOR 8'h0C
`define MON_REGS 17
`define MON_PER_CHAN 6
`define ADC_CH_BASE 8
`define MON_EN_RST 17'h00000
`define OOR_RST 1'b1
`define PIN_SYNC_RST 8'h00
// Monitor enable / out-of-range bit of each regulator
`define MON_CORE_ONE 0
`define MON_CORE_TWO 1
`define MON_PROCESSOR_BUCK 2
`define MON_LINEAR_THREE 3
`define MON_LINEAR_FOUR 4
`define MON_LINEAR_ELEVEN 5
`define MON_IO_BUCK 6
`define MON_MEMORY_BUCK 7
`define MON_PERIPHERAL_BUCK 8
`define MON_LINEAR_ONE 9
`define MON_LINEAR_TWO 10
`define MON_LINEAR_FIVE 11
`define MON_LINEAR_SIX 12
`define MON_LINEAR_SEVEN 13
`define MON_LINEAR_EIGHT 14
`define MON_LINEAR_NINE 15
`define MON_LINEAR_TEN 16
// Status register fields
`define ST_RANGE_BIT 0
`define ST_DONE_BIT 1
`define ST_RESET_BIT 2
`define ST_PG_BIT 3
`define ST_HUB_BIT 4
`define ST_SYSEN_BIT 5
`define ST_STATE_LSB 8
`endif

// ### hw/pwr_seq_pkg.sv
// Types shared by the rail sequencer.
// Assumes the constants header is included where numbers are needed.
package pwr_seq_pkg;
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_AON = 5'h02,
    ST_PDOWN = 5'h04,
    ST_SYS = 5'h08,
    ST_DONE = 5'h10
  } seq_state_t;
endpackage : pwr_seq_pkg

// ### hw/dsw_pg_gate.sv
// Delayed always-on power-good gate.
// Assumes rail_valid and battery_low are already synchronised to pclk.
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module dsw_pg_gate #(
  parameter int unsigned DELAY_CYC = `DSW_PG_DELAY_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Qualifiers
  input wire logic rail_valid,
  input wire logic battery_low,
  // Result
  output logic power_good
);
  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] DELAY_C = CW'(DELAY_CYC);

  logic [CW-1:0] cnt_r;
  wire qualify = rail_valid && !battery_low;
  wire reached = (cnt_r == DELAY_C);

  // Restart the wait on any loss so a brief dip cannot shorten it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!qualify) begin
      cnt_r <= '0;
    end else if (!reached) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // Battery drop gates the output without a register in the path
  assign power_good = reached && qualify;
endmodule : dsw_pg_gate

// ### hw/power_good_rail_sequencing.sv
// Rail sequencer: power-up steps, host reset release, rails-in-range monitor,
// delayed always-on power-good and an APB register file.
// Assumes platform pins are asynchronous to pclk and converter samples are not.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module power_good_rail_sequencing #(
  parameter int unsigned DSW_DELAY_CYC = `DSW_PG_DELAY_CYC,
  parameter int unsigned AON_STEPS = `AON_STEPS_DEF,
  parameter int unsigned SYS_STEPS = `SYS_STEPS_DEF
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Platform pins, asynchronous
  input wire logic dsw_rail_valid,
  input wire logic battery_low,
  input wire logic power_wake_request,
  input wire logic system_domain_enable,
  input wire logic suspend_sleep_request_n,
  input wire logic sleep_state3_control_n,
  input wire logic sleep_state4_control_n,
  input wire logic sleep_state5_control_n,
  // Converter scheduler results, same clock
  input wire logic sample_valid,
  input wire logic [3:0] sample_channel,
  input wire logic [5:0] sample_out_of_range,
  // Power outputs
  output logic delayed_dsw_power_good,
  output logic resume_reset_n,
  output logic rails_in_range,
  output logic hub_load_switch_enable,
  output logic system_rail_enable,
  output logic s0_rail_enable,
  output logic system_domain_done
);
  localparam int PINS = 8;
  localparam logic [3:0] AON_LAST = 4'(AON_STEPS - 1);
  localparam logic [3:0] SYS_LAST = 4'(SYS_STEPS - 1);

  // Pin synchronisers
  logic [PINS-1:0] pin_raw, sync1_r, sync2_r;
  assign pin_raw = {sleep_state5_control_n, sleep_state4_control_n,
                    sleep_state3_control_n, suspend_sleep_request_n,
                    system_domain_enable, power_wake_request, battery_low,
                    dsw_rail_valid};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= `PIN_SYNC_RST;
      sync2_r <= `PIN_SYNC_RST;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  wire dsw_ok_s = sync2_r[0];
  wire batt_low_s = sync2_r[1];
  wire wake_s = sync2_r[2];
  wire sys_en_s = sync2_r[3];
  wire susp_n_s = sync2_r[4];
  wire sleeps_off_s = &sync2_r[7:5];

  // Registers
  logic [`MON_REGS-1:0] mon_en_r, oor_r;
  logic [15:0] step_cfg_r;
  logic [31:0] prdata_r, rd_mux, status_w;

  // Sequencer
  pwr_seq_pkg::seq_state_t state_r, state_nxt;
  logic [3:0] step_r, step_nxt;
  logic [15:0] slot_r, slot_nxt;
  logic hub_r, sysrail_r, s0_r, done_r, reset_n_r, range_r;

  wire in_aon = (state_r == pwr_seq_pkg::ST_AON);
  wire in_sys = (state_r == pwr_seq_pkg::ST_SYS);
  wire in_done = (state_r == pwr_seq_pkg::ST_DONE);
  wire in_pdown = (state_r == pwr_seq_pkg::ST_PDOWN);
  // System steps hold while the host keeps the system enable low
  wire slot_run = in_aon || (in_sys && sys_en_s);
  wire slot_done = slot_run && (slot_r >= step_cfg_r);
  assign slot_nxt = (!slot_run || slot_done) ? 16'h0000 : slot_r + 16'h0001;

  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    case (state_r)
      pwr_seq_pkg::ST_OFF: begin
        if (dsw_ok_s) begin
          state_nxt = pwr_seq_pkg::ST_AON;
          step_nxt = 4'h0;
        end
      end
      pwr_seq_pkg::ST_AON: begin
        if (slot_done && step_r == AON_LAST) begin
          state_nxt = pwr_seq_pkg::ST_PDOWN;
          step_nxt = 4'h0;
        end else if (slot_done) begin
          step_nxt = step_r + 4'h1;
        end
      end
      pwr_seq_pkg::ST_PDOWN: begin
        if (wake_s) begin
          state_nxt = pwr_seq_pkg::ST_SYS;
          step_nxt = 4'h0;
        end
      end
      pwr_seq_pkg::ST_SYS: begin
        if (slot_done && step_r == SYS_LAST) begin
          state_nxt = pwr_seq_pkg::ST_DONE;
        end else if (slot_done) begin
          step_nxt = step_r + 4'h1;
        end
      end
      pwr_seq_pkg::ST_DONE: begin
        if (!sys_en_s) begin
          state_nxt = pwr_seq_pkg::ST_PDOWN;
        end
      end
      default: begin
        state_nxt = pwr_seq_pkg::ST_OFF;
        step_nxt = 4'h0;
      end
    endcase
    // Suspend request from the hub sends the system domain back down
    if ((in_sys || in_done) && !susp_n_s) begin
      state_nxt = pwr_seq_pkg::ST_PDOWN;
      step_nxt = 4'h0;
    end
    if (!dsw_ok_s) begin
      state_nxt = pwr_seq_pkg::ST_OFF;
      step_nxt = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pwr_seq_pkg::ST_OFF;
      step_r <= 4'h0;
      slot_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      slot_r <= slot_nxt;
    end
  end

  // Outputs are registered from the state; reset release needs no rail reading
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hub_r <= 1'b0;
      sysrail_r <= 1'b0;
      s0_r <= 1'b0;
      done_r <= 1'b0;
      reset_n_r <= 1'b0;
    end else begin
      hub_r <= !(state_r == pwr_seq_pkg::ST_OFF) && !(in_aon && step_r < `HUB_SW_STEP);
      sysrail_r <= (in_sys || in_done) && sys_en_s;
      s0_r <= sysrail_r && sleeps_off_s;
      done_r <= in_done;
      reset_n_r <= in_done;
    end
  end

  // Rails-in-range monitor: regulator i sits on channel 8 + i/6, slot i%6
  genvar gi;
  generate
    for (gi = 0; gi < `MON_REGS; gi++) begin : g_mon
      localparam int CH = `ADC_CH_BASE + gi / `MON_PER_CHAN;
      localparam int SL = gi % `MON_PER_CHAN;
      wire hit = sample_valid && (sample_channel == 4'(CH));
      // Out of range until first measured, so an enabled rail cannot pass unseen
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          oor_r[gi] <= `OOR_RST;
        end else if (hit) begin
          oor_r[gi] <= sample_out_of_range[SL];
        end
      end
    end
  endgenerate

  wire any_bad = |(oor_r & mon_en_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_r <= 1'b1;
    end else begin
      range_r <= !any_bad;
    end
  end

  // Delayed always-on power-good
  dsw_pg_gate #(
    .DELAY_CYC(DSW_DELAY_CYC)
  ) u_pg_gate (
    .pclk(pclk),
    .presetn(presetn),
    .rail_valid(dsw_ok_s),
    .battery_low(batt_low_s),
    .power_good(delayed_dsw_power_good)
  );

  // APB: zero wait states, read data captured in the setup cycle
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_mon = (paddr == `OFS_MON_EN);
  wire hit_cfg = (paddr == `OFS_STEP_CFG);
  wire hit_sts = (paddr == `OFS_STATUS);
  wire hit_oor = (paddr == `OFS_OOR);
  wire mapped = hit_mon || hit_cfg || hit_sts || hit_oor;
  wire wr_mon = access && pwrite && hit_mon;
  wire wr_cfg = access && pwrite && hit_cfg;

  always_comb begin
    status_w = 32'h00000000;
    status_w[`ST_RANGE_BIT] = range_r;
    status_w[`ST_DONE_BIT] = done_r;
    status_w[`ST_RESET_BIT] = reset_n_r;
    status_w[`ST_PG_BIT] = delayed_dsw_power_good;
    status_w[`ST_HUB_BIT] = hub_r;
    status_w[`ST_SYSEN_BIT] = sysrail_r;
    status_w[`ST_STATE_LSB +: 5] = state_r;
  end

  assign rd_mux = hit_mon ? {15'h0000, mon_en_r} :
                  hit_cfg ? {16'h0000, step_cfg_r} :
                  hit_sts ? status_w :
                  hit_oor ? {15'h0000, oor_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_en_r <= `MON_EN_RST;
      step_cfg_r <= `STEP_CFG_RST;
      prdata_r <= 32'h00000000;
    end else begin
      if (wr_mon) begin
        mon_en_r <= pwdata[`MON_REGS-1:0];
      end
      if (wr_cfg) begin
        step_cfg_r <= pwdata[15:0];
      end
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign resume_reset_n = reset_n_r;
  assign rails_in_range = range_r;
  assign hub_load_switch_enable = hub_r;
  assign system_rail_enable = sysrail_r;
  assign s0_rail_enable = s0_r;
  assign system_domain_done = done_r;

  // Checks
  logic [31:0] valid_age_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_age_r <= 32'h00000000;
    end else if (!dsw_ok_s || batt_low_s) begin
      valid_age_r <= 32'h00000000;
    end else if (valid_age_r != 32'hFFFFFFFF) begin
      valid_age_r <= valid_age_r + 32'h00000001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_sys_step;
    in_sys && slot_done && step_r == SYS_LAST && susp_n_s && dsw_ok_s;
  endsequence

  sequence s_reached_done;
    s_last_sys_step ##1 in_done;
  endsequence

  property p_pg_delay;
    $rose(delayed_dsw_power_good) |-> valid_age_r >= 32'(DSW_DELAY_CYC);
  endproperty
  a_pg_delay: assert property (p_pg_delay) else $error("power-good rose early");

  property p_pg_batt_drop;
    batt_low_s |-> !delayed_dsw_power_good;
  endproperty
  a_pg_batt_drop: assert property (p_pg_batt_drop) else $error("power-good held on low battery");

  property p_reset_release;
    s_reached_done |=> resume_reset_n;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset not released");

  property p_reset_by_sequence;
    $rose(resume_reset_n) |-> $past(in_done) && $past(state_r, 2) == pwr_seq_pkg::ST_SYS;
  endproperty
  a_reset_by_sequence: assert property (p_reset_by_sequence) else $error("reset left early");

  property p_out_of_range;
    (oor_r[`MON_CORE_ONE] && mon_en_r[`MON_CORE_ONE]) |=> !rails_in_range;
  endproperty
  a_out_of_range: assert property (p_out_of_range) else $error("bad rail not reported");

  property p_channel_sample;
    (sample_valid && sample_channel == 4'(`ADC_CH_BASE + 2)) |=>
      oor_r[`MON_LINEAR_SIX] == $past(sample_out_of_range[0]) && $stable(oor_r[5:0]);
  endproperty
  a_channel_sample: assert property (p_channel_sample) else $error("wrong channel mapping");

  property p_none_enabled;
    (mon_en_r == `MON_EN_RST) [*2] |-> rails_in_range;
  endproperty
  a_none_enabled: assert property (p_none_enabled) else $error("range low with no monitor");

  property p_wake;
    (in_pdown && wake_s && dsw_ok_s) |=> in_sys && step_r == 4'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake request ignored");

  property p_sys_enable;
    system_rail_enable |-> $past(sys_en_s) && ($past(in_sys) || $past(in_done));
  endproperty
  a_sys_enable: assert property (p_sys_enable) else $error("system rails without enable");

  property p_sys_done;
    s_reached_done |=> system_domain_done;
  endproperty
  a_sys_done: assert property (p_sys_done) else $error("system done missing");

  property p_hub_switch;
    (state_r == pwr_seq_pkg::ST_OFF) [*2] |-> !hub_load_switch_enable;
  endproperty
  a_hub_switch: assert property (p_hub_switch) else $error("hub switch on while off");
endmodule : power_good_rail_sequencing

// ### verification/platform_model.sv
// Far-side model: host, platform hub and rail pins around the sequencer.
// Assumes the bench sets the wanted platform state; rail, battery and suspend pins follow one edge later, wake waits for the hub, the rest chain behind wake.
`timescale 1ns/1ps
module platform_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench intent
  input wire logic want_on,
  input wire logic want_sleep,
  input wire logic want_batt_low,
  // Sequencer feedback
  input wire logic hub_load_switch_enable,
  // Platform pins
  output logic dsw_rail_valid,
  output logic battery_low,
  output logic power_wake_request,
  output logic system_domain_enable,
  output logic suspend_sleep_request_n,
  output logic sleep_state3_control_n,
  output logic sleep_state4_control_n,
  output logic sleep_state5_control_n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsw_rail_valid <= 1'b0;
      battery_low <= 1'b0;
      power_wake_request <= 1'b0;
      system_domain_enable <= 1'b0;
      suspend_sleep_request_n <= 1'b1;
      sleep_state3_control_n <= 1'b0;
      sleep_state4_control_n <= 1'b0;
      sleep_state5_control_n <= 1'b0;
    end else begin
      dsw_rail_valid <= want_on;
      battery_low <= want_batt_low;
      // Host wakes only once the hub has its supply
      power_wake_request <= want_on & hub_load_switch_enable & ~want_sleep;
      system_domain_enable <= power_wake_request & ~want_sleep;
      suspend_sleep_request_n <= ~want_sleep;
      sleep_state3_control_n <= system_domain_enable;
      sleep_state4_control_n <= system_domain_enable;
      sleep_state5_control_n <= system_domain_enable;
    end
  end
endmodule : platform_model

// ### verification/tb.sv
// Self-checking bench for the rail sequencer with a platform model.
// Assumes a short power-good delay and a small step length written over APB.
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module tb;
  localparam int DLY = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, want_on, want_sleep, want_batt_low, sample_valid;
  logic [3:0] sample_channel;
  logic [5:0] sample_out_of_range;
  logic dsw_rail_valid, battery_low, power_wake_request, system_domain_enable;
  logic suspend_sleep_request_n, sleep_state3_control_n, sleep_state4_control_n;
  logic sleep_state5_control_n, delayed_dsw_power_good, resume_reset_n;
  logic rails_in_range, hub_load_switch_enable, system_rail_enable;
  logic s0_rail_enable, system_domain_done;
  logic [7:0] obs;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  assign obs = {system_domain_done, s0_rail_enable, system_rail_enable,
                hub_load_switch_enable, rails_in_range, resume_reset_n,
                delayed_dsw_power_good, dsw_rail_valid};

  power_good_rail_sequencing #(.DSW_DELAY_CYC(DLY), .AON_STEPS(3), .SYS_STEPS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dsw_rail_valid(dsw_rail_valid), .battery_low(battery_low),
    .power_wake_request(power_wake_request), .system_domain_enable(system_domain_enable),
    .suspend_sleep_request_n(suspend_sleep_request_n),
    .sleep_state3_control_n(sleep_state3_control_n),
    .sleep_state4_control_n(sleep_state4_control_n),
    .sleep_state5_control_n(sleep_state5_control_n), .sample_valid(sample_valid),
    .sample_channel(sample_channel), .sample_out_of_range(sample_out_of_range),
    .delayed_dsw_power_good(delayed_dsw_power_good), .resume_reset_n(resume_reset_n),
    .rails_in_range(rails_in_range), .hub_load_switch_enable(hub_load_switch_enable),
    .system_rail_enable(system_rail_enable), .s0_rail_enable(s0_rail_enable),
    .system_domain_done(system_domain_done));

  platform_model far_side (
    .pclk(pclk), .presetn(presetn), .want_on(want_on), .want_sleep(want_sleep),
    .want_batt_low(want_batt_low), .hub_load_switch_enable(hub_load_switch_enable),
    .dsw_rail_valid(dsw_rail_valid), .battery_low(battery_low),
    .power_wake_request(power_wake_request), .system_domain_enable(system_domain_enable),
    .suspend_sleep_request_n(suspend_sleep_request_n),
    .sleep_state3_control_n(sleep_state3_control_n),
    .sleep_state4_control_n(sleep_state4_control_n),
    .sleep_state5_control_n(sleep_state5_control_n));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge pclk) begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_bit

  task automatic sample(input logic [3:0] ch, input logic [5:0] oor);
    sample_valid <= 1'b1;
    sample_channel <= ch;
    sample_out_of_range <= oor;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : sample

  task automatic t_regs();
    apb(1'b0, `OFS_MON_EN, 32'h0);
    check(rd, 32'h0);
    check(rails_in_range, 1'b1);
    apb(1'b0, `OFS_STEP_CFG, 32'h0);
    check(rd, {16'h0000, `STEP_CFG_RST});
    apb(1'b1, `OFS_OOR, 32'h0);
    apb(1'b0, `OFS_OOR, 32'h0);
    check(rd, 32'h0001FFFF);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, `OFS_STEP_CFG, 32'h2);
    apb(1'b0, `OFS_STEP_CFG, 32'h0);
    check(rd, 32'h2);
  endtask : t_regs

  task automatic t_power_up();
    want_on <= 1'b1;
    wait_bit(0, 1'b1, 10);
    check(obs[2], 1'b0);
    wait_bit(1, 1'b1, 200);
    check({n >= DLY, n <= DLY + 8}, 2'b11);
    check(obs[4], 1'b1);
    wait_bit(2, 1'b1, 300);
    check(obs[2], 1'b1);
    @(posedge pclk);
    check(obs[7], 1'b1);
    check(obs[6:5], 2'b11);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check({rd[12:8], rd[5:0]}, {pwr_seq_pkg::ST_DONE, 6'h3F});
  endtask : t_power_up

  task automatic t_monitor();
    apb(1'b1, `OFS_MON_EN, 32'h1);
    repeat (2) @(posedge pclk);
    check(rails_in_range, 1'b0);
    sample(4'h8, 6'h00);
    check(rails_in_range, 1'b1);
    sample(4'hA, 6'h10);
    check(rails_in_range, 1'b1);
    apb(1'b1, `OFS_MON_EN, 32'h10001);
    repeat (2) @(posedge pclk);
    check(rails_in_range, 1'b0);
    sample(4'h7, 6'h00);
    check(rails_in_range, 1'b0);
    check(resume_reset_n, 1'b1);
    sample(4'hA, 6'h00);
    check(rails_in_range, 1'b1);
    apb(1'b0, `OFS_OOR, 32'h0);
    check(rd, 32'h00000FC0);
  endtask : t_monitor

  task automatic t_battery();
    want_batt_low <= 1'b1;
    wait_bit(1, 1'b0, 6);
    check(n <= 4, 1'b1);
    check(resume_reset_n, 1'b1);
    @(posedge pclk);
    want_batt_low <= 1'b0;
    wait_bit(1, 1'b1, 200);
    check(n >= DLY, 1'b1);
  endtask : t_battery

  task automatic t_sleep();
    want_sleep <= 1'b1;
    wait_bit(2, 1'b0, 20);
    check(obs[2], 1'b0);
    check(obs[7], 1'b0);
    @(posedge pclk);
    want_sleep <= 1'b0;
    wait_bit(2, 1'b1, 300);
    check(obs[2], 1'b1);
    @(posedge pclk);
    want_on <= 1'b0;
    wait_bit(4, 1'b0, 20);
    check(obs[4], 1'b0);
    check(obs[2:1], 2'b00);
  endtask : t_sleep

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want_on = 1'b0;
    want_sleep = 1'b0;
    want_batt_low = 1'b0;
    sample_valid = 1'b0;
    sample_channel = 4'h0;
    sample_out_of_range = 6'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_power_up();
    t_monitor();
    t_battery();
    t_sleep();
    summarize();
  end
endmodule : tb
